// ==== adpdc_host_model.sv ====
`timescale 1ns/1ps
module adpdc_host_model
	(
	input wire logic ref_clk,
	output logic sclk,
	output logic cs_n,
	output logic frame_sync,
	output logic sdi
	);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		frame_sync = 1'b0;
		sdi = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Half of the 200 ns link clock
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask
	// Top n bits of w, MSB first; n of 0 only selects
	task automatic send_word(input logic [15:0] w, input int n);
		@(negedge ref_clk);
		cs_n = 1'b0;
		half();
		for (int i = 15; i > 15 - n; i--)
		begin
			sdi = w[i];
			half();
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask
	task automatic frame_pulse();
		@(negedge ref_clk);
		frame_sync = 1'b1;
		repeat (8) @(negedge ref_clk);
		frame_sync = 1'b0;
	endtask
endmodule

// ==== adpdc_pkg.sv ====
package adpdc_pkg;

	// Power states, one-hot
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_AUTO = 4'h2,
		ST_SOFT = 4'h4,
		ST_HARD = 4'h8
	} adpdc_state_t;

	// Serial word layout
	localparam int WORD_W = 16;
	localparam int CNT_W = 4;
	localparam logic [WORD_W-1:0] SW_PD_WORD = 16'h8000;
	localparam logic [3:0] CMD_CFG_WRITE = 4'ha;
	localparam int CFG_W = 12;
	localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
	// Reference select position in the configuration word: 1 = external
	localparam int CFG_REF_EXT_BIT = 11;

	// Synchroniser lanes
	localparam int PIN_W = 6;
	localparam int P_SCLK = 0;
	localparam int P_CS_N = 1;
	localparam int P_FRAME = 2;
	localparam int P_START_N = 3;
	localparam int P_PD_N = 4;
	localparam int P_SDI = 5;
	localparam logic [PIN_W-1:0] PIN_RST = 6'h1a;

	// Reference warm-up time
	localparam longint CLK_HZ = 40000000;
	localparam longint WARMUP_MS = 20;
	localparam int WARMUP_CYC = int'((WARMUP_MS * CLK_HZ) / 1000);
	localparam int WARM_W = 20;
	localparam logic [WARM_W-1:0] WARM_ZERO = 20'h00000;

endpackage

// ==== adpdc_sync.sv ====
`timescale 1ns/1ps
module adpdc_sync
	#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
	)
	(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
	);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

// ==== adpdc_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Drop into automatic low-power as soon as each conversion finishes.
// - Keep the internal reference powered during automatic low-power.
// - Wake from automatic low-power within half an SCLK of select activity.
// - Command word 8000h enters software power-down, reference off too.
// - Power-down pin forces full power-down at once, SCLK not needed.
// - Select, frame sync or conversion start wakes software power-down.
// - External reference ready at once; internal needs about 20 ms warm-up after power-down, none after reset.
// - Power-down never changes the stored configuration word.
// - Any power-down restarts the channel sweep from its first channel.
// - Entering any power-down empties the result FIFO.
// - Configuration write loads 12 bits, no end-of-conversion, no conversion.
// - Configuration selects internal or external reference, deciding warm-up.
module adpdc_top
	import adpdc_pkg::*;
	#(
	parameter int WARMUP_CYCLES = WARMUP_CYC
	)
	(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic conversion_start_pin_n,
	input wire logic power_down_pin_n,
	input wire logic sdi,
	input wire logic conv_done,
	output logic analog_on,
	output logic ref_on,
	output logic ready,
	output logic [CFG_W-1:0] config_word,
	output logic config_loaded,
	output logic fifo_clear,
	output logic sweep_restart,
	output logic [3:0] power_state
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [PIN_W-1:0] pins_s;
	logic [PIN_W-1:0] prev_q;
	logic [PIN_W-1:0] prev_d;
	logic sclk_rise;
	logic cs_fall;
	logic frame_rise;
	logic start_fall;
	logic wake_evt;
	logic pd_n_s;
	logic selected;

	adpdc_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in({sdi, power_down_pin_n, conversion_start_pin_n, frame_sync, cs_n, sclk}),
		.sync_out(pins_s)
	);

	always_comb
	begin
		prev_d = pins_s;
		pd_n_s = pins_s[P_PD_N];
		selected = !pins_s[P_CS_N];
		sclk_rise = pins_s[P_SCLK] && !prev_q[P_SCLK];
		cs_fall = !pins_s[P_CS_N] && prev_q[P_CS_N];
		frame_rise = pins_s[P_FRAME] && !prev_q[P_FRAME];
		start_fall = !pins_s[P_START_N] && prev_q[P_START_N];
		wake_evt = cs_fall || frame_rise || start_fall;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			prev_q <= PIN_RST;
		else
			prev_q <= prev_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Serial word capture and decode

	logic [WORD_W-1:0] shift_q;
	logic [WORD_W-1:0] shift_d;
	logic [CNT_W-1:0] bit_q;
	logic [CNT_W-1:0] bit_d;
	logic [WORD_W-1:0] word;
	logic word_done;
	logic sw_hit;
	logic cfg_hit;
	logic [CFG_W-1:0] cfg_q;
	logic [CFG_W-1:0] cfg_d;
	logic cfg_ld_q;
	logic cfg_ld_d;

	always_comb
	begin
		shift_d = shift_q;
		bit_d = bit_q;
		word = {shift_q[WORD_W-2:0], pins_s[P_SDI]};
		word_done = selected && sclk_rise && (bit_q == 4'hf) && pd_n_s;
		sw_hit = word_done && (word == SW_PD_WORD);
		cfg_hit = word_done && (word[WORD_W-1:CFG_W] == CMD_CFG_WRITE);
		if (!selected || frame_rise)
			bit_d = 4'h0;
		else if (sclk_rise)
		begin
			shift_d = word;
			bit_d = bit_q + 4'h1;
		end
		// Only a configuration write touches the word, never a power state
		cfg_d = cfg_hit ? word[CFG_W-1:0] : cfg_q;
		cfg_ld_d = cfg_hit;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			shift_q <= 16'h0000;
			bit_q <= 4'h0;
			cfg_q <= CFG_RST;
			cfg_ld_q <= 1'b0;
		end
		else
		begin
			shift_q <= shift_d;
			bit_q <= bit_d;
			cfg_q <= cfg_d;
			cfg_ld_q <= cfg_ld_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state machine

	adpdc_state_t state_q;
	adpdc_state_t state_d;
	logic pd_enter;
	logic pd_exit;
	logic ref_ext;
	logic clr_q;
	logic clr_d;

	always_comb
	begin
		state_d = state_q;
		if (!pd_n_s)
			state_d = ST_HARD;
		else
		begin
			unique case (state_q)
				ST_ACTIVE:
				begin
					if (sw_hit)
						state_d = ST_SOFT;
					else if (conv_done)
						state_d = ST_AUTO;
				end
				ST_AUTO:
				begin
					if (sw_hit)
						state_d = ST_SOFT;
					else if (wake_evt)
						state_d = ST_ACTIVE;
				end
				ST_SOFT:
				begin
					if (wake_evt)
						state_d = ST_ACTIVE;
				end
				ST_HARD:
					state_d = ST_ACTIVE;
				default:
					state_d = ST_ACTIVE;
			endcase
		end
		pd_enter = (state_d == ST_SOFT || state_d == ST_HARD)
			&& !(state_q == ST_SOFT || state_q == ST_HARD);
		pd_exit = (state_q == ST_SOFT || state_q == ST_HARD) && state_d == ST_ACTIVE;
		clr_d = pd_enter;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_q <= ST_ACTIVE;
			clr_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			clr_q <= clr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference warm-up

	logic [WARM_W-1:0] warm_q;
	logic [WARM_W-1:0] warm_d;

	always_comb
	begin
		ref_ext = cfg_q[CFG_REF_EXT_BIT];
		warm_d = warm_q;
		if (pd_exit)
			warm_d = ref_ext ? WARM_ZERO : WARMUP_CYCLES[WARM_W-1:0];
		else if (warm_q != WARM_ZERO)
			warm_d = warm_q - 20'h00001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			warm_q <= WARM_ZERO;
		else
			warm_q <= warm_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign analog_on = (state_q == ST_ACTIVE);
	assign ref_on = (state_q == ST_ACTIVE) || (state_q == ST_AUTO);
	assign ready = ref_on && (warm_q == WARM_ZERO);
	assign config_word = cfg_q;
	assign config_loaded = cfg_ld_q;
	assign fifo_clear = clr_q;
	assign sweep_restart = clr_q;
	assign power_state = state_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_conv_ends;
		state_q == ST_ACTIVE && conv_done && !sw_hit && pd_n_s;
	endsequence

	sequence s_hw_held;
		!pd_n_s [*2];
	endsequence

	sequence s_pd_entry;
		pd_enter ##1 (state_q == ST_SOFT || state_q == ST_HARD);
	endsequence

	a_auto_after_conv: assert property (@(posedge ref_clk) disable iff (reset)
		s_conv_ends |=> state_q == ST_AUTO && !analog_on && ref_on)
		else $error("no automatic low-power after conversion");

	a_ref_in_auto: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_AUTO |-> ref_on)
		else $error("reference off in automatic low-power");

	a_fast_wake: assert property (@(posedge ref_clk)
		disable iff (reset || !power_down_pin_n || !pd_n_s)
		(state_q == ST_AUTO && $fell(cs_n)) |-> ##[1:3] analog_on)
		else $error("wake from automatic low-power too slow");

	a_soft_entry: assert property (@(posedge ref_clk) disable iff (reset)
		sw_hit && pd_n_s |=> state_q == ST_SOFT && !ref_on && !analog_on)
		else $error("software power-down not entered");

	a_hw_force: assert property (@(posedge ref_clk) disable iff (reset)
		!pd_n_s |=> state_q == ST_HARD && !ref_on)
		else $error("power-down pin not obeyed");

	a_soft_wake: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_SOFT && wake_evt && pd_n_s |=> analog_on)
		else $error("software power-down not woken");

	a_warm_up: assert property (@(posedge ref_clk) disable iff (reset)
		pd_exit |=> (ref_ext ? ready : (!ready && warm_q == WARMUP_CYCLES[WARM_W-1:0])))
		else $error("warm-up does not follow reference choice");

	a_cfg_kept: assert property (@(posedge ref_clk) disable iff (reset)
		!cfg_hit |=> $stable(config_word))
		else $error("configuration word changed without a write");

	a_pd_clears: assert property (@(posedge ref_clk) disable iff (reset)
		s_pd_entry |-> fifo_clear && sweep_restart ##1 !fifo_clear)
		else $error("power-down entry did not clear FIFO and sweep");

	a_cfg_write: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_hit |=> config_loaded && config_word == $past(word[CFG_W-1:0])
			&& $stable(power_state))
		else $error("configuration write wrong");

	a_hw_hold: assert property (@(posedge ref_clk) disable iff (reset)
		s_hw_held |-> state_q == ST_HARD && !analog_on && !ready)
		else $error("woke while power-down pin held");

endmodule

// ==== tb_adc_power_down_control.sv ====
`timescale 1ns/1ps
module tb_adc_power_down_control import adpdc_pkg::*; ;
	localparam int W = 20;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic sclk, cs_n, frame_sync, sdi;
	logic conversion_start_pin_n = 1'b1;
	logic power_down_pin_n = 1'b1;
	logic conv_done = 1'b0;
	logic analog_on, ref_on, ready, config_loaded, fifo_clear, sweep_restart;
	logic [CFG_W-1:0] config_word;
	logic [CFG_W-1:0] cfg_exp = CFG_RST;
	logic [3:0] power_state;
	logic [31:0] rnd;
	int fail_count = 0;
	int tests_run = 0;
	int clr_cnt = 0;
	int swp_cnt = 0;
	int ld_cnt = 0;
	int seed = 32'hd17e;
	int c0, l0;
	always #12.5 ref_clk = ~ref_clk;
	adpdc_top #(.WARMUP_CYCLES(W)) adpdc_top_i (.ref_clk(ref_clk), .reset(reset),
		.sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
		.conversion_start_pin_n(conversion_start_pin_n), .power_down_pin_n(power_down_pin_n),
		.sdi(sdi), .conv_done(conv_done), .analog_on(analog_on), .ref_on(ref_on),
		.ready(ready), .config_word(config_word), .config_loaded(config_loaded),
		.fifo_clear(fifo_clear), .sweep_restart(sweep_restart), .power_state(power_state));
	adpdc_host_model adpdc_host_model_i (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
		.frame_sync(frame_sync), .sdi(sdi));
	always @(posedge ref_clk)
	begin
		if (fifo_clear === 1'b1) clr_cnt++;
		if (sweep_restart === 1'b1) swp_cnt++;
		if (config_loaded === 1'b1) ld_cnt++;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_state(input logic [3:0] exp, input int bound);
		int n = 0;
		while (power_state !== exp && n < bound)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (power_state !== exp)
		begin
			check("state wait", power_state, exp);
			close_out();
		end
	endtask
	task automatic wake(input int s);
		case (s)
			0: adpdc_host_model_i.send_word(16'h0000, 0);
			1: adpdc_host_model_i.frame_pulse();
			default:
			begin
				@(negedge ref_clk);
				conversion_start_pin_n = 1'b0;
				repeat (8) @(negedge ref_clk);
				conversion_start_pin_n = 1'b1;
			end
		endcase
	endtask
	// Internal reference needs the warm-up, external is ready at once
	function automatic logic needs_warm(input logic [CFG_W-1:0] c);
		return !c[CFG_REF_EXT_BIT];
	endfunction
	task automatic check_warm();
		if (needs_warm(cfg_exp))
		begin
			repeat (W - 3) @(negedge ref_clk);
			check("ready in warm-up", ready, 1'b0);
			repeat (6) @(negedge ref_clk);
		end
		else
			repeat (2) @(negedge ref_clk);
		check("ready after wake", ready, 1'b1);
	endtask
	task automatic down_checks();
		check("power outputs", {analog_on, ref_on}, 2'b00);
		check("fifo clears", clr_cnt - c0, 1);
		check("sweep restarts", swp_cnt, clr_cnt);
		check("config kept", config_word, cfg_exp);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		check("config reset", config_word, CFG_RST);
		for (int s = 0; s < 3; s++)
		begin
			c0 = clr_cnt;
			conv_done = 1'b1;
			@(negedge ref_clk);
			conv_done = 1'b0;
			check("auto state", power_state, ST_AUTO);
			check("auto power", {analog_on, ref_on}, 2'b01);
			fork
				wake(s);
				wait_state(ST_ACTIVE, 4);
			join
			check("auto ready", ready, 1'b1);
			check("auto clears", clr_cnt - c0, 0);
		end
		$display("test automatic power-down done");
		for (int s = 0; s < 3; s++)
		begin
			rnd = $random(seed);
			rnd[CFG_REF_EXT_BIT] = s[0];
			l0 = ld_cnt;
			adpdc_host_model_i.send_word({CMD_CFG_WRITE, rnd[CFG_W-1:0]}, 16);
			cfg_exp = rnd[CFG_W-1:0];
			check("config write", config_word, cfg_exp);
			check("config loads", ld_cnt - l0, 1);
			check("no conversion", power_state, ST_ACTIVE);
			c0 = clr_cnt;
			adpdc_host_model_i.send_word(SW_PD_WORD, 16);
			wait_state(ST_SOFT, 4);
			down_checks();
			fork
				wake(s);
				// Warm-up counts from the wake itself, not from the end of the wake pulse
				begin
					wait_state(ST_ACTIVE, 12);
					check_warm();
				end
			join
			check("config after soft", config_word, cfg_exp);
		end
		$display("test software power-down done");
		c0 = clr_cnt;
		l0 = ld_cnt;
		@(negedge ref_clk);
		power_down_pin_n = 1'b0;
		wait_state(ST_HARD, 4);
		repeat (3) @(negedge ref_clk);
		down_checks();
		for (int s = 0; s < 3; s++)
			wake(s);
		adpdc_host_model_i.send_word({CMD_CFG_WRITE, ~cfg_exp}, 16);
		check("hard holds", power_state, ST_HARD);
		check("hard no load", ld_cnt - l0, 0);
		@(negedge ref_clk);
		power_down_pin_n = 1'b1;
		wait_state(ST_ACTIVE, 4);
		check("config after hard", config_word, cfg_exp);
		check_warm();
		$display("test hardware power-down done");
		close_out();
	end
endmodule
